// ---- logic/csau_consts.vh ----
// Function
// - Live charger-enabled bit is enable control AND bias above lockout.
// - Charger phase code sits at bits 6:4; 000 standby, 010 prequalify.
// - Supply low bit 2, high 1, near-battery 0; low forced if disabled.
// - Bit 7 is boost on and output below OV-falling; reading has no effect.
// - Boost alert sets on activation edge; read clears until next activation.
// - Constant-voltage alert sets on entry to CV state; read clears it.
// - Charge-done alert sets on entry to done state; read clears it.
// - Supply alert held while any supply flag set; read clears only if none.
// - Thermal-limit alert held in reduced-current mode; read clears after end.
// - Thermal-shutdown alert held while engaged; read clears once ended.
// - Sink overcurrent alert held while sink at 3A or battery pin low.
// - Alert pin driven from OR of general status terms gated by mask bits.
// - A term joins the OR only when its mask bit is 1.
// - Mask resets with bit 7 at 1, bit 6 at 0; all bits read/write.
// - Both status registers are read-only; writes change nothing.
// - Serial bus access: address, register byte, data byte; combined read.
`ifndef CSAU_CONSTS_VH
`define CSAU_CONSTS_VH

`define CSAU_OFS_CHARGER     8'h01
`define CSAU_OFS_GENERAL     8'h02
`define CSAU_OFS_MASK        8'h03
`define CSAU_MASK_RESET      8'h80
`define CSAU_DEV_ADDR        7'h28
`define CSAU_PHASE_STANDBY   3'h0
`define CSAU_PHASE_PREQUAL   3'h2
`define CSAU_BIT_BOOST_LIVE  7
`define CSAU_BIT_BOOST_ALERT 6
`define CSAU_BIT_CV_ALERT    5
`define CSAU_BIT_DONE_ALERT  4
`define CSAU_BIT_SUPPLY      3
`define CSAU_BIT_THERM_LIM   2
`define CSAU_BIT_THERM_SD    1
`define CSAU_BIT_SINK_OC     0
`define CSAU_IN_WIDTH        16

`endif

// ---- logic/csau_sync.v ----
`default_nettype none
module csau_sync #(
  parameter integer W  = 1,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  input  wire         clk,   // Sampling clock
  input  wire         rst,   // Async reset, active high
  input  wire [W-1:0] d,     // Asynchronous inputs
  output reg  [W-1:0] q      // Synchronised outputs
);
  reg [W-1:0] meta_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RV;
      q      <= RV;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- logic/csau_top.v ----
`include "csau_consts.vh"
`default_nettype none
module csau_top #(
  parameter [6:0] DEV_ADDR = `CSAU_DEV_ADDR
) (
  input  wire       ref_clk,                // 10 MHz block clock
  input  wire       sys_rst,                // Async reset, active high
  input  wire       scl_pin,                // Serial clock pin level
  input  wire       sda_pin,                // Serial data pin level
  output reg        sda_drive,              // Serial data drive value
  output reg        sda_oe_n,               // Low while data pin driven
  input  wire       alert_pin_n,            // Alert pin level
  output reg        alert_out_n,            // Alert pin drive value
  output reg        alert_oe_n,             // Low while alert pin pulled
  input  wire       charge_enable_ctl,      // Charger enable control bit
  input  wire       bias_above_uvlo,        // Bias above lockout
  input  wire [2:0] charger_phase_code,     // Charger state code
  input  wire       supply_one_low,         // Supply-1 below 3.5V
  input  wire       supply_one_high,        // Supply-1 above 7.0V
  input  wire       supply_one_near_batt,   // Supply-1 below batt+100mV
  input  wire       boost_enable_ctl,       // Boost enable control bit
  input  wire       boost_below_ovf,        // Supply-2 below OV falling
  input  wire       charger_in_cv,          // Charger in fast-charge CV
  input  wire       charger_done,           // Charger in charge-done
  input  wire       thermal_limit,          // Reduced-current thermal mode
  input  wire       thermal_shutdown,       // Thermal protection engaged
  input  wire       sink_at_limit,          // Sink current reached 3A
  input  wire       battery_plus_uv         // Battery-plus undervoltage
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACK  = 9'h004;
  localparam [8:0] S_WREG = 9'h008;
  localparam [8:0] S_DATA = 9'h010;
  localparam [8:0] S_READ = 9'h020;
  localparam [8:0] S_MACK = 9'h040;
  localparam [8:0] S_SKIP = 9'h080;
  localparam [8:0] S_RLD  = 9'h100;

  // Pin and analog inputs come from outside the clock domain
  wire [1:0] bus_s;
  wire [`CSAU_IN_WIDTH-1:0] in_s;

  csau_sync #(.W(2), .RV(2'h3)) u_bus_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({scl_pin, sda_pin}),
    .q   (bus_s)
  );

  csau_sync #(.W(`CSAU_IN_WIDTH)) u_in_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({charge_enable_ctl, bias_above_uvlo, charger_phase_code,
           supply_one_low, supply_one_high, supply_one_near_batt,
           boost_enable_ctl, boost_below_ovf, charger_in_cv,
           charger_done, thermal_limit, thermal_shutdown,
           sink_at_limit, battery_plus_uv}),
    .q   (in_s)
  );

  wire       charge_enable_ctl_s   = in_s[15];
  wire       bias_ok_s  = in_s[14];
  wire [2:0] phase_s    = in_s[13:11];
  wire       low_s      = in_s[10];
  wire       high_s     = in_s[9];
  wire       nearb_s    = in_s[8];
  wire       boost_enable_ctl_s   = in_s[7];
  wire       bst_blw_s  = in_s[6];
  wire       cv_s       = in_s[5];
  wire       done_s     = in_s[4];
  wire       tlim_s     = in_s[3];
  wire       tsd_s      = in_s[2];
  wire       sink_s     = in_s[1];
  wire       bplus_uv_s = in_s[0];

  wire scl_s = bus_s[1];
  wire sda_s = bus_s[0];

  // Charger status, all live
  wire       charger_active_live   = charge_enable_ctl_s & bias_ok_s;
  wire       supply_one_low_flag   = low_s | ~charge_enable_ctl_s;
  wire       supply_one_high_flag  = high_s;
  wire       supply_one_near_battery_flag = nearb_s;
  wire [7:0] charger_state_flags = {charger_active_live,
                                    phase_s,
                                    1'b0,
                                    supply_one_low_flag,
                                    supply_one_high_flag,
                                    supply_one_near_battery_flag};

  wire boost_live = boost_enable_ctl_s & bst_blw_s;
  wire sup_any    = supply_one_low_flag | supply_one_high_flag |
                    supply_one_near_battery_flag;
  wire soh_cond   = sink_s | bplus_uv_s;

  reg       boost_prev_q;
  reg       cv_prev_q;
  reg       done_prev_q;
  reg       boost_started_alert_q;
  reg       const_voltage_alert_q;
  reg       charge_done_alert_q;
  reg       supply_fault_alert_q;
  reg       thermal_limit_alert_q;
  reg       thermal_shutdown_alert_q;
  reg       sink_overcurrent_alert_q;
  reg       rd_clr_q;
  reg [7:0] rd_snap_q;
  reg [7:0] mask_q;

  // Only bits the host was shown are cleared; a later edge event is kept
  wire [7:0] rd_clr_bits = {8{rd_clr_q}} & rd_snap_q;

  wire [7:0] general_alert_flags = {boost_live,
                                    boost_started_alert_q,
                                    const_voltage_alert_q,
                                    charge_done_alert_q,
                                    supply_fault_alert_q,
                                    thermal_limit_alert_q,
                                    thermal_shutdown_alert_q,
                                    sink_overcurrent_alert_q};

  // Set terms are ORed last so an event in the clearing cycle survives
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boost_prev_q             <= 1'b0;
      cv_prev_q                <= 1'b0;
      done_prev_q              <= 1'b0;
      boost_started_alert_q    <= 1'b0;
      const_voltage_alert_q    <= 1'b0;
      charge_done_alert_q      <= 1'b0;
      supply_fault_alert_q     <= 1'b0;
      thermal_limit_alert_q    <= 1'b0;
      thermal_shutdown_alert_q <= 1'b0;
      sink_overcurrent_alert_q <= 1'b0;
    end else begin
      boost_prev_q <= boost_live;
      cv_prev_q    <= cv_s;
      done_prev_q  <= done_s;
      boost_started_alert_q <= (boost_started_alert_q & ~rd_clr_bits[6]) |
                               (boost_live & ~boost_prev_q);
      const_voltage_alert_q <= (const_voltage_alert_q & ~rd_clr_bits[5]) |
                               (cv_s & ~cv_prev_q);
      charge_done_alert_q   <= (charge_done_alert_q & ~rd_clr_bits[4]) |
                               (done_s & ~done_prev_q);
      supply_fault_alert_q  <= (supply_fault_alert_q & ~rd_clr_bits[3]) |
                               sup_any;
      thermal_limit_alert_q <= (thermal_limit_alert_q & ~rd_clr_bits[2]) |
                               tlim_s;
      thermal_shutdown_alert_q <= (thermal_shutdown_alert_q &
                                   ~rd_clr_bits[1]) | tsd_s;
      sink_overcurrent_alert_q <= (sink_overcurrent_alert_q &
                                   ~rd_clr_bits[0]) | soh_cond;
    end
  end

  // Open-drain alert: value held low, enable carries the state
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_out_n <= 1'b0;
      alert_oe_n  <= 1'b1;
    end else begin
      alert_out_n <= 1'b0;
      alert_oe_n  <= ~|(general_alert_flags & mask_q);
    end
  end

  // Serial slave
  reg       scl_p_q;
  reg       sda_p_q;
  reg [8:0] state_q;
  reg [8:0] ack_nxt_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [7:0] sh_in = {sh_q[6:0], sda_s};

  reg [7:0] rd_data;
  always @* begin
    case (ptr_q)
      `CSAU_OFS_CHARGER: rd_data = charger_state_flags;
      `CSAU_OFS_GENERAL: rd_data = general_alert_flags;
      `CSAU_OFS_MASK:    rd_data = mask_q;
      default:           rd_data = 8'h00;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      state_q   <= S_IDLE;
      ack_nxt_q <= S_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rd_snap_q <= 8'h00;
      mask_q    <= `CSAU_MASK_RESET;
      sda_drive <= 1'b0;
      sda_oe_n  <= 1'b1;
      rd_clr_q  <= 1'b0;
    end else begin
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
      rd_clr_q <= 1'b0;
      sda_drive <= 1'b0;
      if (bus_stop) begin
        state_q  <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (bus_start) begin
        state_q  <= S_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_n <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE, S_SKIP: begin
            sda_oe_n <= 1'b1;
          end
          S_ADDR, S_WREG, S_DATA: begin
            if (scl_rise) begin
              sh_q  <= sh_in;
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (state_q == S_ADDR) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  state_q   <= S_ACK;
                  sda_oe_n  <= 1'b0;
                  ack_nxt_q <= sh_q[0] ? S_RLD : S_WREG;
                end else begin
                  state_q <= S_SKIP;
                end
              end else begin
                if (state_q == S_WREG) begin
                  ptr_q <= sh_q;
                end else if (ptr_q == `CSAU_OFS_MASK) begin
                  mask_q <= sh_q;
                end
                // Status registers ignore written data
                state_q   <= S_ACK;
                sda_oe_n  <= 1'b0;
                ack_nxt_q <= S_DATA;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (ack_nxt_q == S_RLD) begin
                sh_q      <= rd_data;
                rd_snap_q <= rd_data;
                sda_oe_n <= rd_data[7];
                state_q  <= S_READ;
              end else begin
                sda_oe_n <= 1'b1;
                state_q  <= ack_nxt_q;
              end
            end
          end
          S_READ: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                cnt_q    <= 4'h0;
                sda_oe_n <= 1'b1;
                state_q  <= S_MACK;
                if (ptr_q == `CSAU_OFS_GENERAL) begin
                  rd_clr_q <= 1'b1;
                end
              end else begin
                sh_q     <= {sh_q[6:0], 1'b0};
                sda_oe_n <= sh_q[6];
              end
            end
          end
          S_MACK: begin
            // Host acknowledge asks for the same register again
            if (scl_rise) begin
              state_q <= sda_s ? S_SKIP : S_RLD;
            end
          end
          S_RLD: begin
            if (scl_fall) begin
              sh_q      <= rd_data;
              rd_snap_q <= rd_data;
              sda_oe_n <= rd_data[7];
              state_q  <= S_READ;
            end
          end
          default: begin
            state_q  <= S_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/csau_i2c_host.sv ----
`default_nettype none
module csau_i2c_host (
  input  wire logic ref_clk, // Paces the bus
  input  wire logic sda,     // Resolved data line
  output var  logic scl,     // Serial clock, 800 ns period
  output var  logic sda_lo   // High while host pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;
  int nack_cnt = 0;
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic qtr();
    repeat (2) @(negedge ref_clk);
  endtask
  // Data moves only in the clock-low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    sda_lo = !b;
    qtr();
    scl = 1'b1;
    qtr();
    s = sda;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic byte_io(input logic [7:0] v, input logic chk,
                         output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    if (chk && s) nack_cnt++;
  endtask
  task automatic start();
    sda_lo = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_lo = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_lo = 1'b0;
    qtr();
    qtr();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] rg, d);
    logic [7:0] r;
    start();
    byte_io({a, 1'b0}, 1'b1, r);
    byte_io(rg, 1'b1, r);
    byte_io(d, 1'b1, r);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] rg,
                    output logic [7:0] d);
    start();
    byte_io({a, 1'b0}, 1'b1, d);
    byte_io(rg, 1'b1, d);
    start();
    byte_io({a, 1'b1}, 1'b1, d);
    byte_io(8'hFF, 1'b0, d);
    stop();
  endtask
endmodule
`default_nettype wire

// ---- sim/csau_sva.sv ----
`default_nettype none
module csau_sva (
  input wire logic ref_clk,     // Block clock
  input wire logic sys_rst,     // Async reset, active high
  input wire logic scl_pin,     // Serial clock level
  input wire logic sda_pin,     // Serial data level
  input wire logic sda_drive,   // Data drive value
  input wire logic sda_oe_n,    // Low while data pulled
  input wire logic alert_out_n, // Alert drive value
  input wire logic alert_oe_n   // Low while alert pulled
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] scl_hi_q;
  // Saturating count tells an idle bus from a single clock-high phase
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst) scl_hi_q <= 4'h0;
    else if (!scl_pin) scl_hi_q <= 4'h0;
    else if (scl_hi_q != 4'hF) scl_hi_q <= scl_hi_q + 4'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> (alert_oe_n && sda_oe_n) [*3])
    else $error("pin driven right after reset");
  a_sda_drive_zero: assert property (
    !sda_oe_n |-> !sda_drive) else $error("data driven high");
  a_alert_drive_zero: assert property (
    !alert_oe_n |-> !alert_out_n) else $error("alert driven high");
  a_sda_change_low: assert property (
    $changed(sda_oe_n) |-> !$past(scl_pin))
    else $error("data changed while clock high");
  a_sda_min_hold: assert property (
    $fell(sda_oe_n) |-> !sda_oe_n [*4]) else $error("data bit too short");
  a_sda_hold_bound: assert property (
    !sda_oe_n |-> ##[0:100] sda_oe_n) else $error("data held too long");
  a_idle_released: assert property (
    scl_hi_q == 4'hF |-> sda_oe_n) else $error("data driven on idle bus");
  a_stop_releases: assert property (
    $rose(sda_pin) && scl_pin && $past(scl_pin) |-> sda_oe_n [*8])
    else $error("data driven after stop");
endmodule
bind csau_top csau_sva csau_sva_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl_pin),
  .sda_pin(sda_pin), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n),
  .alert_out_n(alert_out_n), .alert_oe_n(alert_oe_n));
`default_nettype wire

// ---- sim/tb_csau_top.sv ----
`include "csau_consts.vh"
`default_nettype none
`define CSAU_CHK(n, e, a) begin \
  compares++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("wrong value %s expected %h seen %h", n, e, a); \
  end \
end
module tb_csau_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] A = `CSAU_DEV_ADDR;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] st = 16'hC000;
  logic        scl, sda_lo, sda_out, sda_oe_n, alert_out_n, alert_oe_n;
  logic [7:0]  rv, b, z, m;
  int          err_total = 0;
  int          compares = 0;
  logic [15:0] chg_in [5] = '{16'hC000, 16'hD000, 16'h4000, 16'h8000,
                              16'hC700};
  logic [15:0] src_in [7] = '{16'h0400, 16'h0008, 16'h0004, 16'h0002,
                              16'h0001, 16'h0020, 16'h0010};
  logic [7:0]  src_bit [7] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h20,
                               8'h10};
  wire         sda = !(sda_lo || (!sda_oe_n && !sda_out));
  wire         alert_pin = alert_oe_n || alert_out_n;
  always #50 ref_clk = !ref_clk;
  csau_top csau_top_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_pin(sda),
    .sda_drive(sda_out), .sda_oe_n(sda_oe_n), .alert_pin_n(alert_pin),
    .alert_out_n(alert_out_n), .alert_oe_n(alert_oe_n),
    .charge_enable_ctl(st[15]), .bias_above_uvlo(st[14]),
    .charger_phase_code(st[13:11]), .supply_one_low(st[10]),
    .supply_one_high(st[9]), .supply_one_near_batt(st[8]),
    .boost_enable_ctl(st[7]), .boost_below_ovf(st[6]),
    .charger_in_cv(st[5]), .charger_done(st[4]), .thermal_limit(st[3]),
    .thermal_shutdown(st[2]), .sink_at_limit(st[1]),
    .battery_plus_uv(st[0]));
  csau_i2c_host csau_i2c_host_inst (
    .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    csau_i2c_host_inst.rd(A, r, d);
  endtask
  task automatic wr(input logic [7:0] r, d);
    csau_i2c_host_inst.wr(A, r, d);
  endtask
  // Two reads back to back: the second shows what clear-on-read left
  task automatic probe(input logic [15:0] s, input logic [7:0] e1, e2);
    st = s;
    repeat (6) @(negedge ref_clk);
    rd(`CSAU_OFS_GENERAL, rv);
    `CSAU_CHK("general first", e1, rv)
    rd(`CSAU_OFS_GENERAL, rv);
    `CSAU_CHK("general second", e2, rv)
  endtask
  function automatic logic [7:0] chg_exp(input logic [15:0] s);
    return {s[15] & s[14], s[13:11], 1'b0, s[10] | !s[15], s[9:8]};
  endfunction
  task automatic test_done();
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rd(`CSAU_OFS_MASK, rv);
    `CSAU_CHK("mask reset", 8'h80, rv)
    csau_i2c_host_inst.wr(A ^ 7'h01, `CSAU_OFS_MASK, 8'h00);
    `CSAU_CHK("nacks", 3, csau_i2c_host_inst.nack_cnt)
    rd(`CSAU_OFS_MASK, rv);
    `CSAU_CHK("mask kept", 8'h80, rv)
    rd(8'h10, rv);
    `CSAU_CHK("unmapped", 8'h00, rv)
    foreach (chg_in[i]) begin
      st = chg_in[i];
      repeat (6) @(negedge ref_clk);
      rd(`CSAU_OFS_CHARGER, rv);
      `CSAU_CHK("charger", chg_exp(st), rv)
    end
    probe(16'hC000, 8'h08, 8'h00);
    foreach (src_in[i]) begin
      b = src_bit[i];
      z = (i < 5) ? b : 8'h00;
      probe(16'hC000 | src_in[i], b, z);
      probe(16'hC000, z, 8'h00);
    end
    probe(16'hC0C0, 8'hC0, 8'h80);
    probe(16'hC080, 8'h00, 8'h00);
    probe(16'hC0C0, 8'hC0, 8'h80);
    probe(16'hC000, 8'h00, 8'h00);
    wr(`CSAU_OFS_CHARGER, 8'hFF);
    wr(`CSAU_OFS_GENERAL, 8'hFF);
    rd(`CSAU_OFS_CHARGER, rv);
    `CSAU_CHK("charger ro", 8'h80, rv)
    rd(`CSAU_OFS_GENERAL, rv);
    `CSAU_CHK("general ro", 8'h00, rv)
    `CSAU_CHK("ro acked", 3, csau_i2c_host_inst.nack_cnt)
    st = 16'hC0C8;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(`CSAU_OFS_MASK, m);
      rd(`CSAU_OFS_MASK, rv);
      `CSAU_CHK("mask rw", m, rv)
      `CSAU_CHK("alert pin", !(|(m & 8'hC4)), alert_pin)
    end
    test_done();
  end
endmodule
`default_nettype wire
